/* File: design/aocc_defines.svh */
// Register addresses, field positions, reset values and fixed codes
`ifndef AOCC_DEFINES_SVH
`define AOCC_DEFINES_SVH
`define AOCC_ADDR_CONV        7'h00
`define AOCC_ADDR_CONFIG      7'h02
`define AOCC_ADDR_CHANNEL     7'h03
`define AOCC_WR_BIT           15
`define AOCC_ADDR_MSB         15
`define AOCC_SEL_MSB          14
`define AOCC_ADDR_LSB         9
`define AOCC_OS_MSB           4
`define AOCC_OS_LSB           2
`define AOCC_STATUS_EN_BIT    1
`define AOCC_CRC_EN_BIT       0
`define AOCC_CH_B_MSB         7
`define AOCC_CH_B_LSB         4
`define AOCC_CH_A_MSB         3
`define AOCC_CH_A_LSB         0
`define AOCC_CONFIG_RESET     9'h000
`define AOCC_CHANNEL_RESET    9'h000
`define AOCC_TEST_CODE_A      16'hAAAA
`define AOCC_TEST_CODE_B      16'h5555
`define AOCC_CODE_TEST        4'hB
`endif

/* File: design/aocc_pkg.sv */
// Types shared by the configuration and channel register block
package aocc_pkg;
  typedef enum logic [1:0] {
    AOCC_SRC_PAIR,
    AOCC_SRC_SUPPLY,
    AOCC_SRC_REGULATOR,
    AOCC_SRC_TEST
  } aocc_source_t;

  typedef enum logic [2:0] {
    AOCC_RD_REG,
    AOCC_RD_CONV_A,
    AOCC_RD_CONV_B,
    AOCC_RD_STATUS
  } aocc_read_state_t;
endpackage

/* File: design/aocc_chan_decode.sv */
// Decoder for one converter channel select field
`include "aocc_defines.svh"
module aocc_chan_decode (
  input  wire logic [3:0]            code,
  output aocc_pkg::aocc_source_t     source,
  output logic      [2:0]            pair,
  output logic                       reserved
);
  import aocc_pkg::*;

  always_comb begin
    pair     = code[2:0];
    reserved = 1'b0;
    source   = AOCC_SRC_PAIR;
    unique case (code)
      4'h8: begin
        source = AOCC_SRC_SUPPLY;
      end
      4'h9: begin
        source = AOCC_SRC_REGULATOR;
      end
      `AOCC_CODE_TEST: begin
        source = AOCC_SRC_TEST;
      end
      4'hA, 4'hC, 4'hD, 4'hE, 4'hF: begin
        reserved = 1'b1;
      end
      default: begin
        source = AOCC_SRC_PAIR;
      end
    endcase
  end
endmodule

/* File: design/aocc_regs.sv */
// Configuration low bits and channel register with 16-bit frame access
// Behaviour
// - The three-bit oversample field resets to zero, 000 means off and 001..111 mean ratios 2 to 128.
// - With both append enables clear (reset) no status word follows the conversion words.
// - With it set the status word follows the last conversion word when every selected channel is read.
// - The low eight bits of the appended status word carry the CRC result.
// - The CRC append enable at bit 0 acts exactly like the status append enable and both reset to zero.
// - In manual mode the channel register picks the pair or internal source for the next conversion.
// - Converter B field codes 0..7 pick pairs, 8 the supply monitor, 9 the regulator, 10 and 12 to 15 are reserved.
// - Code 1011 in a converter's own field makes its read conversion code 0xAAAA for converter A or 0x5555 for converter B.
// - Converter A field sits in the low bits, decodes the same way, is read/write and resets to zero.
// - The channel register resets to all zeros, pair 0 on both converters.
// - Each register word holds its address in the upper seven bits and a reserved zero bit 8.
// - Frame bit 15 set writes the low nine bits; clear makes the next operation a read.
// - Address 00010 is the configuration register and 00011 the channel register.
// - A read frame with address zero returns conversion codes instead of register contents.
`include "aocc_defines.svh"
module aocc_regs (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   frame_valid,
  input  wire logic [15:0]            frame_data,
  input  wire logic                   word_pop,
  input  wire logic [15:0]            conv_code_a,
  input  wire logic [15:0]            conv_code_b,
  input  wire logic                   all_channels_read,
  input  wire logic [7:0]             crc_result,
  input  wire logic [7:0]             status_upper,
  output logic      [15:0]            read_word,
  output logic                        read_valid,
  output logic      [2:0]             oversample_ratio_field,
  output logic                        oversample_on,
  output logic      [7:0]             oversample_ratio,
  output logic                        append_status,
  output aocc_pkg::aocc_source_t      source_a,
  output aocc_pkg::aocc_source_t      source_b,
  output logic      [2:0]             pair_a,
  output logic      [2:0]             pair_b,
  output logic                        channel_reserved
);
  import aocc_pkg::*;

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    logic [8:0]       config_bits;
    logic [8:0]       channel_bits;
    aocc_read_state_t rd_state;
    logic [15:0]      word;
    logic             valid;
  } aocc_state_t;

  aocc_state_t state_reg;
  aocc_state_t state_next;

  aocc_source_t dec_src_a;
  aocc_source_t dec_src_b;
  logic [2:0]   dec_pair_a;
  logic [2:0]   dec_pair_b;
  logic         dec_res_a;
  logic         dec_res_b;

  // ********************************
  // Helper functions
  // ********************************
  // Register address of a frame; bit 15 is the write flag and never part of the address
  function automatic logic [6:0] frame_addr(input logic [15:0] f);
    frame_addr = {1'b0, f[`AOCC_SEL_MSB:`AOCC_ADDR_LSB]};
  endfunction

  function automatic logic addr_is(input logic [15:0] f, input logic [6:0] a);
    addr_is = (frame_addr(f) == a);
  endfunction

  function automatic logic [15:0] reg_word(input logic [6:0] addr, input logic [8:0] bits);
    reg_word = {addr, 1'b0, bits[7:0]};
  endfunction

  // Only the oversample and append bits live here; bits 8:5 read back as zero
  function automatic logic [8:0] config_from(input logic [15:0] f);
    config_from = {4'h0, f[`AOCC_OS_MSB:`AOCC_CRC_EN_BIT]};
  endfunction

  // Reserved bit 8 is stored as zero so reads show zero
  function automatic logic [8:0] channel_from(input logic [15:0] f);
    channel_from = {1'b0, f[`AOCC_CH_B_MSB:`AOCC_CH_A_LSB]};
  endfunction

  // Samples per channel; one when oversampling is off
  function automatic logic [7:0] ratio_of(input logic [2:0] field);
    logic [7:0] r;
    r = 8'h01;
    unique case (field)
      3'h0: r = 8'h01;
      3'h1: r = 8'h02;
      3'h2: r = 8'h04;
      3'h3: r = 8'h08;
      3'h4: r = 8'h10;
      3'h5: r = 8'h20;
      3'h6: r = 8'h40;
      3'h7: r = 8'h80;
    endcase
    ratio_of = r;
  endfunction

  // Self-test pattern replaces the result; the converter itself keeps running
  function automatic logic [15:0] conv_or_pattern(input aocc_source_t src,
                                                  input logic [15:0] pattern,
                                                  input logic [15:0] conv);
    conv_or_pattern = (src == AOCC_SRC_TEST) ? pattern : conv;
  endfunction

  function automatic logic [15:0] status_word(input logic [7:0] upper,
                                              input logic [7:0] crc);
    status_word = {upper, crc};
  endfunction

  // Unhandled addresses answer with their address and zero data
  function automatic logic [15:0] readback(input logic [6:0] addr,
                                           input logic [8:0] cfg,
                                           input logic [8:0] chan);
    logic [15:0] w;
    w = reg_word(addr, 9'h000);
    if (addr == `AOCC_ADDR_CONFIG) begin
      w = reg_word(addr, cfg);
    end else if (addr == `AOCC_ADDR_CHANNEL) begin
      w = reg_word(addr, chan);
    end
    readback = w;
  endfunction

  // ********************************
  // Decoders
  // ********************************
  aocc_chan_decode u_dec_a (
    .code     (state_reg.channel_bits[`AOCC_CH_A_MSB:`AOCC_CH_A_LSB]),
    .source   (dec_src_a),
    .pair     (dec_pair_a),
    .reserved (dec_res_a)
  );

  aocc_chan_decode u_dec_b (
    .code     (state_reg.channel_bits[`AOCC_CH_B_MSB:`AOCC_CH_B_LSB]),
    .source   (dec_src_b),
    .pair     (dec_pair_b),
    .reserved (dec_res_b)
  );

  // ********************************
  // Frame decode
  // ********************************
  logic        frame_write;
  logic        frame_read;
  logic        hit_conv;
  logic        hit_config;
  logic        hit_channel;
  logic        take_pop;
  logic [15:0] code_a;
  logic [15:0] code_b;

  assign frame_write = frame_valid & frame_data[`AOCC_WR_BIT];
  assign frame_read  = frame_valid & ~frame_data[`AOCC_WR_BIT];
  assign hit_conv    = addr_is(frame_data, `AOCC_ADDR_CONV);
  assign hit_config  = addr_is(frame_data, `AOCC_ADDR_CONFIG);
  assign hit_channel = addr_is(frame_data, `AOCC_ADDR_CHANNEL);
  assign take_pop    = word_pop & state_reg.valid;
  assign code_a      = conv_or_pattern(dec_src_a, `AOCC_TEST_CODE_A, conv_code_a);
  assign code_b      = conv_or_pattern(dec_src_b, `AOCC_TEST_CODE_B, conv_code_b);

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    state_next = state_reg;
    // Pop walks the conversion burst: word A, word B, then the optional status word
    if (take_pop) begin
      state_next.valid = 1'b0;
      unique case (state_reg.rd_state)
        AOCC_RD_CONV_A: begin
          state_next.word     = code_b;
          state_next.valid    = 1'b1;
          state_next.rd_state = AOCC_RD_CONV_B;
        end
        AOCC_RD_CONV_B: begin
          // Status only when the host drained every selected channel
          if (append_status && all_channels_read) begin
            state_next.word     = status_word(status_upper, crc_result);
            state_next.valid    = 1'b1;
            state_next.rd_state = AOCC_RD_STATUS;
          end else begin
            state_next.rd_state = AOCC_RD_REG;
          end
        end
        default: begin
          state_next.rd_state = AOCC_RD_REG;
        end
      endcase
    end
    // A read frame in the same cycle as a pop wins; the host restarts the readout
    if (frame_write) begin
      if (hit_config) begin
        state_next.config_bits = config_from(frame_data);
      end else if (hit_channel) begin
        state_next.channel_bits = channel_from(frame_data);
      end
    end
    if (frame_read) begin
      state_next.valid = 1'b1;
      if (hit_conv) begin
        state_next.word     = code_a;
        state_next.rd_state = AOCC_RD_CONV_A;
      end else begin
        state_next.word     = readback(frame_addr(frame_data), state_reg.config_bits,
                                       state_reg.channel_bits);
        state_next.rd_state = AOCC_RD_REG;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg.config_bits  <= `AOCC_CONFIG_RESET;
      state_reg.channel_bits <= `AOCC_CHANNEL_RESET;
      state_reg.rd_state     <= AOCC_RD_REG;
      state_reg.word         <= 16'h0000;
      state_reg.valid        <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign read_word              = state_reg.word;
  assign read_valid             = state_reg.valid;
  assign oversample_ratio_field = state_reg.config_bits[`AOCC_OS_MSB:`AOCC_OS_LSB];
  assign oversample_on          = (oversample_ratio_field != 3'h0);
  assign oversample_ratio       = ratio_of(oversample_ratio_field);
  assign append_status          = state_reg.config_bits[`AOCC_STATUS_EN_BIT]
                                | state_reg.config_bits[`AOCC_CRC_EN_BIT];
  assign source_a               = dec_src_a;
  assign source_b               = dec_src_b;
  assign pair_a                 = dec_pair_a;
  assign pair_b                 = dec_pair_b;
  assign channel_reserved       = dec_res_a | dec_res_b;
endmodule

/* File: test/aocc_host.sv */
// Host controller model issuing command frames and consuming read words
module aocc_host (
  input  wire logic        sys_clk,
  output logic             frame_valid,
  output logic [15:0]      frame_data,
  output logic             word_pop
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    frame_valid = 1'b0;
    frame_data  = 16'h0000;
    word_pop    = 1'b0;
  end
  // Released frame bits carry the inverse so a stale frame never looks live
  task automatic send(input logic [15:0] f);
    @(posedge sys_clk) #1;
    frame_valid = 1'b1;
    frame_data  = f;
    @(posedge sys_clk) #1;
    frame_valid = 1'b0;
    frame_data  = ~f;
  endtask
  task automatic pop;
    @(posedge sys_clk) #1;
    word_pop = 1'b1;
    @(posedge sys_clk) #1;
    word_pop = 1'b0;
  endtask
endmodule

/* File: test/aocc_regs_props.sv */
// Port-level checks for the configuration and channel register block
module aocc_regs_props import aocc_pkg::*; (
  input wire logic          sys_clk,
  input wire logic          rst,
  input wire logic          frame_valid,
  input wire logic [15:0]   frame_data,
  input wire logic          word_pop,
  input wire logic [15:0]   conv_code_a,
  input wire logic [15:0]   read_word,
  input wire logic          read_valid,
  input wire logic [2:0]    oversample_ratio_field,
  input wire logic          oversample_on,
  input wire logic [7:0]    oversample_ratio,
  input wire logic          append_status,
  input aocc_source_t       source_a,
  input wire logic [2:0]    pair_a
);
  logic wcfg;
  logic wchan;
  logic rd0;
  assign wcfg  = frame_valid && frame_data[15] && frame_data[14:9] == 6'h02;
  assign wchan = frame_valid && frame_data[15] && frame_data[14:9] == 6'h03;
  assign rd0   = frame_valid && frame_data[15:9] == 7'h00;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_os_field: assert property (wcfg |=> oversample_ratio_field == $past(frame_data[4:2]))
    else $error("oversample field not stored");
  chk_os_ratio: assert property (oversample_on == (oversample_ratio_field != 3'h0)
    && oversample_ratio == (oversample_on ? 8'h01 << oversample_ratio_field : 8'h01)) else $error("bad ratio");
  chk_append_or: assert property (wcfg |=> append_status == ($past(frame_data[1]) | $past(frame_data[0])))
    else $error("append enable wrong");
  chk_read_answer: assert property (frame_valid && !frame_data[15] |=> read_valid)
    else $error("read not answered");
  chk_addr_echo: assert property (frame_valid && !frame_data[15] && frame_data[14:9] != 6'h00
    |=> read_word[15:8] == {$past(frame_data[15:9]), 1'b0}) else $error("address not echoed");
  chk_conv_word: assert property (rd0 && source_a != AOCC_SRC_TEST |=> read_word == $past(conv_code_a))
    else $error("conversion word wrong");
  chk_test_code: assert property (rd0 && source_a == AOCC_SRC_TEST |=> read_word == 16'hAAAA)
    else $error("test code wrong");
  chk_pair_a: assert property (wchan && !frame_data[3] |=> source_a == AOCC_SRC_PAIR
    && pair_a == $past(frame_data[2:0])) else $error("pair decode wrong");
  chk_word_hold: assert property (read_valid && !word_pop && !frame_valid |=> read_valid && $stable(read_word))
    else $error("read word dropped");
endmodule

/* File: test/tb_aocc_regs.sv */
// Self-checking bench for the configuration and channel register block
module tb_aocc_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import aocc_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, frame_valid, word_pop, all_channels_read = 1'b1;
  logic [15:0] frame_data, read_word, conv_code_a = 16'h1234, conv_code_b = 16'hFEDC;
  logic [7:0] crc_result = 8'h5A, status_upper = 8'hC3, oversample_ratio;
  logic [2:0] oversample_ratio_field, pair_a, pair_b;
  logic read_valid, oversample_on, append_status, channel_reserved;
  aocc_source_t source_a, source_b;
  int n_errors = 0, checks_done = 0, cycles = 0;
  always #2.5 sys_clk = ~sys_clk;
  aocc_host i_host (.sys_clk, .frame_valid, .frame_data, .word_pop);
  aocc_regs i_dut (.sys_clk, .rst, .frame_valid, .frame_data, .word_pop, .conv_code_a, .conv_code_b,
    .all_channels_read, .crc_result, .status_upper, .read_word, .read_valid, .oversample_ratio_field,
    .oversample_on, .oversample_ratio, .append_status, .source_a, .source_b, .pair_a, .pair_b, .channel_reserved);
  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [8:0] d);
    i_host.send({1'b1, a, d});
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    i_host.send({1'b0, a, 9'h000});
    chk(16'(read_valid), 16'h0001);
    chk(read_word, e);
  endtask
  task automatic pk(input logic [15:0] e);
    i_host.pop;
    chk(read_word, e);
  endtask
  task automatic t_reset;
    rd(6'h02, 16'h0400);
    rd(6'h03, 16'h0600);
    chk({7'h00, append_status, oversample_ratio}, 16'h0001);
  endtask
  task automatic t_os;
    for (int c = 0; c < 8; c++) begin
      wr(6'h02, 9'(c << 2));
      chk({5'h00, oversample_ratio_field, oversample_ratio}, {5'h00, 3'(c), (c == 0) ? 8'h01 : 8'(1 << c)});
      chk(16'(oversample_on), 16'(c != 0));
      rd(6'h02, 16'h0400 | 16'(c << 2));
    end
  endtask
  // Case 3 sets both enables but leaves a channel unread, so no status word may follow
  task automatic t_append;
    for (int m = 0; m < 4; m++) begin
      all_channels_read = (m != 3);
      wr(6'h02, 9'(m));
      rd(6'h00, conv_code_a);
      pk(conv_code_b);
      i_host.pop;
      if (m == 1 || m == 2) begin
        chk(read_word, {status_upper, crc_result});
        i_host.pop;
      end
      chk(16'(read_valid), 16'h0000);
    end
  endtask
  task automatic t_chan;
    aocc_source_t s;
    for (int c = 0; c < 13; c++) begin
      s = (c == 8) ? AOCC_SRC_SUPPLY : (c == 9) ? AOCC_SRC_REGULATOR : (c == 11) ? AOCC_SRC_TEST : AOCC_SRC_PAIR;
      wr(6'h03, {1'b0, 4'(c), 4'(c)});
      chk({12'h000, source_a, source_b}, {12'h000, s, s});
      chk(16'(channel_reserved), 16'(c == 10 || c == 12));
      if (c < 8) chk({10'h000, pair_a, pair_b}, {10'h000, 3'(c), 3'(c)});
      rd(6'h03, 16'h0600 | 16'(c * 17));
    end
  endtask
  task automatic t_test;
    wr(6'h03, 9'h0BB);
    rd(6'h00, 16'hAAAA);
    pk(16'h5555);
  endtask
  task automatic t_refuse;
    wr(6'h02, 9'h1FF);
    rd(6'h02, 16'h041F);
    wr(6'h05, 9'h000);
    rd(6'h02, 16'h041F);
    rd(6'h05, 16'h0A00);
  endtask
  // Ceiling sits far above the roughly 160 cycles the scenarios need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      conclude;
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    #1 rst = 1'b0;
    t_reset;
    t_os;
    t_append;
    t_chan;
    t_test;
    t_refuse;
    conclude;
  end
endmodule
bind aocc_regs aocc_regs_props i_props (.sys_clk, .rst, .frame_valid, .frame_data, .word_pop, .conv_code_a,
  .read_word, .read_valid, .oversample_ratio_field, .oversample_on, .oversample_ratio, .append_status,
  .source_a, .pair_a);
